// [include/smc_consts.svh]
// Purpose: constants of the standby mode control block
// Assumes: register index times four gives the byte address
// Notes:   reset values are those of the control registers
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
// register indices
`define SMC_IDX_STOP_CODE   6'h0e
`define SMC_IDX_STANDBY     6'h0f
`define SMC_IDX_PERIPH      6'h15
`define SMC_IDX_STATUS      6'h20
// reset values
`define SMC_RST_STANDBY     8'h08
`define SMC_RST_PERIPH      8'h8c
// standby control fields
`define SMC_BIT_STOP        0
`define SMC_BIT_HALT        1
`define SMC_BIT_FLOAT       2
`define SMC_BIT_OSC_STOP    3
`define SMC_BIT_SUBCLK      7
// peripheral control field
`define SMC_BIT_HOLD_EN     5
// stop code nibbles
`define SMC_CODE_FIRST      4'h5
`define SMC_CODE_SECOND     4'ha
`endif

// [include/smc_pkg.sv]
// Purpose: types of the standby mode control block
// Assumes: nothing beyond the constants header
// Notes:   one packed struct holds all state
package smc_pkg;
  typedef enum logic [1:0] {
    SMC_RUN  = 2'b00,
    SMC_HALT = 2'b01,
    SMC_HOLD = 2'b10,
    SMC_STOP = 2'b11
  } smc_mode_e;

  typedef struct packed {
    logic        cpu_clk_en;
    logic        periph_clk_en;
    logic        tbc_run;
    logic        rtc_run;
    logic        wdt_run;
    logic        bus_release;
    logic        bus_ack;
    logic        float_out;
    logic        osc_en;
    logic        low_speed;
    logic        dev_reset;
  } smc_ctl_s;

  typedef struct packed {
    smc_mode_e   mode;
    logic [7:0]  standby;
    logic [7:0]  periph;
    logic        acceptor;
    logic        saw_first;
    logic        ap_valid;
    logic        ap_write;
    logic [5:0]  ap_idx;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    smc_ctl_s    ctl;
  } smc_state_s;
endpackage

// [logic/smc_top.sv]
// Purpose: standby modes and reset gathering behind an AHB-Lite slave
// Assumes: all inputs synchronous to i_clk_sys, 40 MHz
// Notes:   zero wait states; every output is a flip-flop
//
// Notes on behaviour
// RL1 - halt is entered by software only and gates the cpu clock
// RL2 - hold is entered by hardware request and gates the cpu clock
// RL3 - stop is entered by software and gates cpu and peripheral clocks
// RL4 - in hold the external bus is released to the outside master
// RL5 - stop with oscillator kept running gives a quick wake
// RL6 - reset pin, break instruction or invalid opcode reset the device
// RL7 - watchdog overflow also resets the whole device
// RL8 - every mode exists at high speed and at low speed
// RL9 - stop request enters stop only when acceptor already set
// RL10 - in hold, bus-function port outputs are released
// RL11 - hold needs hold enable bit 5 and the request pin high
// RL12 - time base and peripherals run in halt and hold, stop in stop
// RL13 - acceptor set by consecutive writes n5 then na, cleared on stop
// RL14 - halt bit enters halt; interrupt, pin or watchdog reset clear it
// RL15 - interrupt or pin reset clears stop bit and leaves stop
// RL16 - float bit set makes outputs high impedance during stop
// RL17 - hold ends when the request pin falls or on pin reset
// RL18 - real-time counter always runs; watchdog halted during hold
`include "smc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module smc_top
  import smc_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_hold_req,
  input  wire logic        i_ext_reset_pin_n,
  input  wire logic        i_break_instruction,
  input  wire logic        i_invalid_opcode,
  input  wire logic        i_wdt_overflow,
  input  wire logic        i_irq,
  output logic             o_cpu_clk_en,
  output logic             o_periph_clk_en,
  output logic             o_time_base_counter_run,
  output logic             o_rtc_run,
  output logic             o_watchdog_timer_run,
  output logic             o_bus_release,
  output logic             o_bus_release_acknowledge,
  output logic             o_float_outputs,
  output logic             o_main_osc_en,
  output logic             o_low_speed,
  output logic             o_device_reset
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] reg_index(input logic [31:0] addr);
    reg_index = addr[7:2];
  endfunction

  function automatic smc_state_s reset_state();
    smc_state_s r;
    r                   = '0;
    r.mode              = SMC_RUN;
    r.standby           = `SMC_RST_STANDBY;
    r.periph            = `SMC_RST_PERIPH;
    r.hreadyout         = 1'b1;
    r.ctl.cpu_clk_en    = 1'b1;
    r.ctl.periph_clk_en = 1'b1;
    r.ctl.tbc_run       = 1'b1;
    r.ctl.rtc_run       = 1'b1;
    r.ctl.wdt_run       = 1'b1;
    r.ctl.osc_en        = 1'b1;
    reset_state = r;
  endfunction

  smc_state_s st_reg;
  smc_state_s st_next;
  logic       dev_rst;
  logic       data_wr;
  logic       stop_code_wr;
  logic       standby_wr;

  ////////////////////////////////////////////////////////////////////////
  // reset sources are gathered here; the pin is active low
  assign dev_rst = ~i_ext_reset_pin_n | i_break_instruction
                 | i_invalid_opcode | i_wdt_overflow; // see RL6 see RL7
  assign data_wr      = st_reg.ap_valid & st_reg.ap_write;
  assign stop_code_wr = data_wr & (st_reg.ap_idx == `SMC_IDX_STOP_CODE);
  assign standby_wr   = data_wr & (st_reg.ap_idx == `SMC_IDX_STANDBY);

  always_comb begin
    st_next        = st_reg;
    st_next.hresp  = 1'b0;
    st_next.hreadyout = 1'b1;
    // interrupt clears first so a write in the same cycle still wins
    if (i_irq) begin
      st_next.standby[`SMC_BIT_HALT] = 1'b0; // see RL14
      st_next.standby[`SMC_BIT_STOP] = 1'b0; // see RL15
    end
    if (stop_code_wr) begin
      st_next.saw_first = (i_hwdata[3:0] == `SMC_CODE_FIRST);
      if (st_reg.saw_first && i_hwdata[3:0] == `SMC_CODE_SECOND) begin
        st_next.acceptor = 1'b1; // see RL13
      end
    end
    if (standby_wr) begin
      st_next.standby[7:1] = i_hwdata[7:1]; // see RL14
      // a stop request without the code sequence is dropped
      if (i_hwdata[`SMC_BIT_STOP] && st_reg.acceptor) begin
        st_next.standby[`SMC_BIT_STOP] = 1'b1; // see RL9
        st_next.acceptor               = 1'b0; // see RL13
      end
    end
    if (data_wr && st_reg.ap_idx == `SMC_IDX_PERIPH) begin
      st_next.periph = i_hwdata[7:0];
    end
    // mode priority: stop, then hold, then halt
    if (st_next.standby[`SMC_BIT_STOP]) begin
      st_next.mode = SMC_STOP; // see RL3
    end else if (st_reg.mode == SMC_HOLD ? i_hold_req
        : (st_next.periph[`SMC_BIT_HOLD_EN] && i_hold_req)) begin
      st_next.mode = SMC_HOLD; // see RL2 see RL11 see RL17
    end else if (st_next.standby[`SMC_BIT_HALT]) begin
      st_next.mode = SMC_HALT; // see RL1
    end else begin
      st_next.mode = SMC_RUN;
    end
    st_next.ctl.cpu_clk_en    = (st_next.mode == SMC_RUN); // see RL1 see RL2
    st_next.ctl.periph_clk_en = (st_next.mode != SMC_STOP); // see RL3
    st_next.ctl.tbc_run       = (st_next.mode != SMC_STOP); // see RL12
    st_next.ctl.rtc_run       = 1'b1; // see RL18
    st_next.ctl.wdt_run       = (st_next.mode == SMC_RUN)
                              || (st_next.mode == SMC_HALT); // see RL18
    st_next.ctl.bus_release   = (st_next.mode == SMC_HOLD); // see RL4 see RL10
    // acknowledge follows once the bus has been let go for a cycle
    st_next.ctl.bus_ack       = st_next.ctl.bus_release
                              & st_reg.ctl.bus_release;
    st_next.ctl.float_out     = (st_next.mode == SMC_STOP)
                              & st_next.standby[`SMC_BIT_FLOAT]; // see RL16
    // oscillator stays on unless stop with osc-stop chosen
    st_next.ctl.osc_en        = !((st_next.mode == SMC_STOP)
                              && st_next.standby[`SMC_BIT_OSC_STOP]); // see RL5
    st_next.ctl.low_speed     = st_next.standby[`SMC_BIT_SUBCLK]; // see RL8
    st_next.ctl.dev_reset     = 1'b0;
    // address phase; read data is taken from the updated copy
    st_next.ap_valid = i_hsel & i_hready & i_htrans[1];
    st_next.ap_write = i_hwrite;
    st_next.ap_idx   = reg_index(i_haddr);
    st_next.hrdata   = '0;
    if (st_next.ap_valid && !i_hwrite) begin
      unique case (reg_index(i_haddr))
        `SMC_IDX_STANDBY: st_next.hrdata[7:0] = st_next.standby;
        `SMC_IDX_PERIPH:  st_next.hrdata[7:0] = st_next.periph;
        `SMC_IDX_STATUS:  st_next.hrdata[4:0] = {st_next.ctl.bus_release,
                            st_next.acceptor, st_next.ctl.low_speed,
                            st_next.mode}; // see RL8
        default:          st_next.hrdata = '0;
      endcase
    end
    // any device reset source returns everything to defaults
    if (dev_rst) begin
      st_next               = reset_state(); // see RL6 see RL7 see RL17
      st_next.ctl.dev_reset = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st_reg <= reset_state();
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign o_hrdata                  = st_reg.hrdata;
  assign o_hreadyout               = st_reg.hreadyout;
  assign o_hresp                   = st_reg.hresp;
  assign o_cpu_clk_en              = st_reg.ctl.cpu_clk_en;
  assign o_periph_clk_en           = st_reg.ctl.periph_clk_en;
  assign o_time_base_counter_run   = st_reg.ctl.tbc_run;
  assign o_rtc_run                 = st_reg.ctl.rtc_run;
  assign o_watchdog_timer_run      = st_reg.ctl.wdt_run;
  assign o_bus_release             = st_reg.ctl.bus_release;
  assign o_bus_release_acknowledge = st_reg.ctl.bus_ack;
  assign o_float_outputs           = st_reg.ctl.float_out;
  assign o_main_osc_en             = st_reg.ctl.osc_en;
  assign o_low_speed               = st_reg.ctl.low_speed;
  assign o_device_reset            = st_reg.ctl.dev_reset;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  sequence s_first_code;
    stop_code_wr && i_hwdata[3:0] == `SMC_CODE_FIRST && !dev_rst;
  endsequence

  // checked at the spacing of a single-transfer master: two idle cycles
  sequence s_code_gap;
    (!stop_code_wr && !dev_rst) [*2];
  endsequence

  sequence s_second_code;
    stop_code_wr && i_hwdata[3:0] == `SMC_CODE_SECOND && !dev_rst;
  endsequence

  sequence s_code_written;
    s_first_code ##1 s_code_gap ##1 s_second_code;
  endsequence

  property p_halt_gates;
    st_reg.mode == SMC_HALT |-> !o_cpu_clk_en && o_periph_clk_en;
  endproperty
  a_halt_gates: assert property (p_halt_gates) // see RL1
    else $error("halt mode left cpu clock running");

  property p_halt_timers;
    st_reg.mode == SMC_HALT |-> o_time_base_counter_run
      && o_watchdog_timer_run && o_main_osc_en && !o_bus_release;
  endproperty
  a_halt_timers: assert property (p_halt_timers) // see RL12
    else $error("halt mode stopped a timer");

  property p_stop_gates;
    st_reg.mode == SMC_STOP |-> !o_cpu_clk_en && !o_periph_clk_en
      && !o_time_base_counter_run && o_rtc_run;
  endproperty
  a_stop_gates: assert property (p_stop_gates) // see RL3
    else $error("stop mode left a clock running");

  property p_hold_enter;
    !dev_rst && !standby_wr && !st_reg.standby[`SMC_BIT_STOP]
      && !(data_wr && st_reg.ap_idx == `SMC_IDX_PERIPH)
      && st_reg.periph[`SMC_BIT_HOLD_EN] && i_hold_req
      && st_reg.mode != SMC_STOP
      |=> o_bus_release && !o_cpu_clk_en && !o_watchdog_timer_run
          ##1 o_bus_release_acknowledge == o_bus_release;
  endproperty
  a_hold_enter: assert property (p_hold_enter) // see RL11
    else $error("hold request not honoured");

  property p_hold_needs_en;
    $rose(o_bus_release) |-> st_reg.periph[`SMC_BIT_HOLD_EN]
      && $past(i_hold_req);
  endproperty
  a_hold_needs_en: assert property (p_hold_needs_en) // see RL11
    else $error("bus released without hold enable and request");

  property p_hold_exit;
    st_reg.mode == SMC_HOLD && !i_hold_req && !st_reg.standby[0]
      |=> !o_bus_release;
  endproperty
  a_hold_exit: assert property (p_hold_exit) // see RL17
    else $error("bus still released after hold request fell");

  property p_hold_clocks;
    st_reg.mode == SMC_HOLD |-> !o_cpu_clk_en && !o_watchdog_timer_run
      && o_rtc_run && o_time_base_counter_run && o_bus_release;
  endproperty
  a_hold_clocks: assert property (p_hold_clocks) // see RL18
    else $error("hold mode clock or watchdog control wrong");

  property p_stop_guard;
    standby_wr && i_hwdata[0] && !st_reg.acceptor && !dev_rst
      && st_reg.mode != SMC_STOP |=> st_reg.mode != SMC_STOP;
  endproperty
  a_stop_guard: assert property (p_stop_guard) // see RL9
    else $error("stop entered without stop code");

  property p_code_seq;
    s_code_written |=> st_reg.acceptor;
  endproperty
  a_code_seq: assert property (p_code_seq) // see RL13
    else $error("stop code sequence did not set acceptor");

  property p_irq_wakes;
    i_irq && !data_wr && !dev_rst |=> !st_reg.standby[0]
      && !st_reg.standby[1] && (o_cpu_clk_en || o_bus_release);
  endproperty
  a_irq_wakes: assert property (p_irq_wakes) // see RL14
    else $error("interrupt did not release halt or stop");

  property p_reset_src;
    dev_rst |=> o_device_reset && o_cpu_clk_en && !o_bus_release
      && st_reg.standby == `SMC_RST_STANDBY && !st_reg.acceptor;
  endproperty
  a_reset_src: assert property (p_reset_src) // see RL6
    else $error("reset source did not reset the block");

  property p_float_osc;
    st_reg.mode == SMC_STOP |-> o_float_outputs == st_reg.standby[2]
      && o_main_osc_en == !st_reg.standby[3];
  endproperty
  a_float_osc: assert property (p_float_osc) // see RL16
    else $error("float or oscillator control wrong in stop");

  property p_run_clocks;
    st_reg.mode == SMC_RUN |-> o_cpu_clk_en && o_periph_clk_en
      && o_watchdog_timer_run && !o_bus_release && !o_float_outputs;
  endproperty
  a_run_clocks: assert property (p_run_clocks) // see RL12
    else $error("run mode left a clock stopped");

  property p_speed_select;
    !dev_rst && standby_wr
      |=> o_low_speed == $past(i_hwdata[`SMC_BIT_SUBCLK]);
  endproperty
  a_speed_select: assert property (p_speed_select) // see RL8
    else $error("clock speed select did not follow the write");

endmodule // smc_top

`default_nettype wire

// [test/smc_hold_master.sv]
// Purpose: outside bus master that asks for the bus on the hold pin
// Assumes: the bench commands it through i_want
// Notes:   i_slow stretches its reaction to four cycles, as a slow
//          master would, so release timing is not always prompt
`timescale 1ns/1ps
`default_nettype none

module smc_hold_master (
  input  wire logic i_clk_sys,
  input  wire logic i_want,
  input  wire logic i_slow,
  output logic      o_hold_req
);
  logic [2:0] wait_reg;

  initial o_hold_req = 1'b0;
  initial wait_reg = 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // the pin level moves only after the reaction delay has run out
  always @(posedge i_clk_sys) begin
    if (i_want == o_hold_req) begin
      wait_reg <= 3'h0;
    end else if (wait_reg >= (i_slow ? 3'h3 : 3'h0)) begin
      o_hold_req <= i_want;
      wait_reg   <= 3'h0;
    end else begin
      wait_reg <= wait_reg + 3'h1;
    end
  end
endmodule // smc_hold_master
`default_nettype wire

// [test/tb_standby_mode_control.sv]
// Purpose: self-checking bench of the standby mode control block
// Assumes: one slave on the bus, so its hreadyout is the bus hready
// Notes:   outputs are sampled at the falling edge to stay clear of races
`timescale 1ns/1ps
`default_nettype none
`include "smc_consts.svh"

module tb_standby_mode_control
  import smc_pkg::*;
;
  typedef struct packed {
    logic        code;
    logic [7:0]  sby;
    logic [10:0] exp;
  } smc_row_s;

  // ctl bits: cpu periph tbc rtc wdt rel ack flt osc low rst
  smc_row_s rows [6] = '{
    '{1'b0, 8'h02, 11'b01111000100}, '{1'b0, 8'h82, 11'b01111000110},
    '{1'b0, 8'h01, 11'b11111000100}, '{1'b1, 8'h01, 11'b00010000100},
    '{1'b1, 8'h05, 11'b00010001100}, '{1'b1, 8'h89, 11'b00010000010}};

  logic        clk, srst, hsel, hwrite, hreadyout, hresp, irq;
  logic        want, slow, hold_req, pin_n, break_instruction, opc, wdt;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire smc_ctl_s ctl;
  int          n_errors = 0;
  int          samples_checked = 0;

  smc_top dut (.i_clk_sys(clk), .i_srst(srst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout),
    .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
    .i_hold_req(hold_req), .i_ext_reset_pin_n(pin_n),
    .i_break_instruction(break_instruction), .i_invalid_opcode(opc),
    .i_wdt_overflow(wdt), .i_irq(irq),
    .o_cpu_clk_en(ctl.cpu_clk_en), .o_periph_clk_en(ctl.periph_clk_en),
    .o_time_base_counter_run(ctl.tbc_run), .o_rtc_run(ctl.rtc_run),
    .o_watchdog_timer_run(ctl.wdt_run), .o_bus_release(ctl.bus_release),
    .o_bus_release_acknowledge(ctl.bus_ack),
    .o_float_outputs(ctl.float_out), .o_main_osc_en(ctl.osc_en),
    .o_low_speed(ctl.low_speed), .o_device_reset(ctl.dev_reset));

  smc_hold_master u_master (.i_clk_sys(clk), .i_want(want), .i_slow(slow),
    .o_hold_req(hold_req));

  ////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  // bounded wait for one ctl bit; running out ends the run
  task await_bit(input int b, input logic v, input string nm);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ctl[b] !== v && n < 10);
    chk(nm, {31'h0, v}, {31'h0, ctl[b]});
    if (ctl[b] !== v) tally_and_finish();
  endtask

  // one single word transfer: address phase, then data phase
  task bus(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    int   n;
    logic rdy;
    logic rsp;
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(negedge clk);
        rdy = hreadyout;
        rd  = hrdata;
        rsp = hresp;
        @(posedge clk);
        n++;
      end while (rdy !== 1'b1 && n < 16);
      if (rdy !== 1'b1) begin
        n_errors++;
        tally_and_finish();
      end
      if (p == 0) begin
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
      end
    end
    chk("hresp", 32'h0, {31'h0, rsp});
  endtask

  task pulse_irq;
    @(posedge clk);
    irq <= 1'b1;
    @(posedge clk);
    irq <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    {srst, pin_n, hsize} = {1'b1, 1'b1, 3'b010};
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {want, slow, break_instruction, opc, wdt, irq} = '0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("ctl", 32'h004 | 32'h7c0, {21'h0, ctl});
    bus(1'b0, `SMC_IDX_STANDBY, 32'h0);
    chk("standby", 32'h08, rd);
    bus(1'b0, `SMC_IDX_PERIPH, 32'h0);
    chk("periph", 32'h8c, rd);
    bus(1'b1, 6'h01, 32'hff);
    bus(1'b0, 6'h01, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("reset test done");
    foreach (rows[i]) begin
      if (rows[i].code) begin
        bus(1'b1, `SMC_IDX_STOP_CODE, 32'h35);
        bus(1'b1, `SMC_IDX_STOP_CODE, 32'h7a);
      end
      bus(1'b1, `SMC_IDX_STANDBY, {24'h0, rows[i].sby});
      @(negedge clk);
      chk("ctl", {21'h0, rows[i].exp}, {21'h0, ctl});
      pulse_irq();
      await_bit(10, 1'b1, "cpu_clk_en");
    end
    $display("mode table done");
    // a broken sequence must not arm the acceptor
    bus(1'b1, `SMC_IDX_STOP_CODE, 32'h35);
    bus(1'b1, `SMC_IDX_STOP_CODE, 32'h3c);
    bus(1'b1, `SMC_IDX_STOP_CODE, 32'h3a);
    bus(1'b1, `SMC_IDX_STANDBY, 32'h01);
    @(negedge clk);
    chk("cpu_clk_en", 32'h1, {31'h0, ctl.cpu_clk_en});
    bus(1'b1, `SMC_IDX_STOP_CODE, 32'h05);
    bus(1'b1, `SMC_IDX_STOP_CODE, 32'hfa);
    bus(1'b0, `SMC_IDX_STATUS, 32'h0);
    chk("status", 32'h08, rd);
    bus(1'b1, `SMC_IDX_STANDBY, 32'h01);
    bus(1'b0, `SMC_IDX_STATUS, 32'h0);
    chk("status", 32'h03, rd);
    pulse_irq();
    await_bit(10, 1'b1, "cpu_clk_en");
    bus(1'b1, `SMC_IDX_STANDBY, 32'h01);
    @(negedge clk);
    chk("cpu_clk_en", 32'h1, {31'h0, ctl.cpu_clk_en});
    $display("stop code test done");
    want <= 1'b1;
    repeat (6) @(negedge clk);
    chk("bus_release", 32'h0, {31'h0, ctl.bus_release});
    bus(1'b1, `SMC_IDX_PERIPH, 32'hac);
    await_bit(5, 1'b1, "bus_release");
    chk("ctl", 32'h3a4, {21'h0, ctl});
    @(negedge clk);
    chk("ack", 32'h1, {31'h0, ctl.bus_ack});
    slow <= 1'b1;
    want <= 1'b0;
    await_bit(5, 1'b0, "bus_release");
    want <= 1'b1;
    await_bit(5, 1'b1, "bus_release");
    @(posedge clk);
    pin_n <= 1'b0;
    @(posedge clk);
    pin_n <= 1'b1;
    await_bit(5, 1'b0, "bus_release");
    want <= 1'b0;
    $display("hold test done");
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, `SMC_IDX_STANDBY, 32'h82);
      @(posedge clk);
      {pin_n, break_instruction, opc, wdt} <= {s != 0, s == 1, s == 2, s == 3};
      @(posedge clk);
      {pin_n, break_instruction, opc, wdt} <= 4'h8;
      await_bit(0, 1'b1, "device_reset");
      await_bit(10, 1'b1, "cpu_clk_en");
      bus(1'b0, `SMC_IDX_STANDBY, 32'h0);
      chk("standby", 32'h08, rd);
    end
    $display("reset source test done");
    tally_and_finish();
  end
endmodule // tb_standby_mode_control
`default_nettype wire
